// >>> design/lbce_top.sv
/*
 * Ladder bit-control engine: runs a scan over a stored program and
 * executes coil, edge-pulse and latch steps on a 64-bit data memory.
 * Bits 0..15 mirror input pins, 16..31 drive output pins, the rest
 * are work bits. Assumes an APB master and synchronous input pins.
 */
// What this block does
// - Bit-control steps end a line and name one operand bit.
// - Rising-edge pulse sets operand one scan on OFF-to-ON condition.
// - Falling-edge pulse sets operand one scan on ON-to-OFF condition.
// - Next execution after a pulse clears the operand bit.
// - Falling-edge pulse keeps operand OFF until a falling edge.
// - Rising pulse is code 10, falling pulse code 11.
// - Edge-pulse step is one word holding its operand.
// - Latch sets operand when its set line is ON.
// - Latch clears operand when its reset line is ON.
// - Both latch lines ON means reset wins.
// - Latch operand holds while its section gate is OFF.
// - Sealed coil keeps its state between scans.
// - Coil inside a closed section is driven OFF.
// - Work bits are never copied to or from pins.
// - Closed section freezes latches and edge pulses and forces coils OFF.
// - Closed section drives both coil and inverted-coil steps OFF.
`timescale 1ns/1ns
module lbce_top
    import lbce_pkg::*;
#(
    parameter int unsigned N_EDGE = EDGE_MAX
) (
    input  wire logic            pclk,     // Clock, 25 MHz
    input  wire logic            presetn,  // Async reset, low
    input  wire logic            ce,       // Clock enable
    input  wire logic            psel,     // APB select
    input  wire logic            penable,  // APB access phase
    input  wire logic            pwrite,   // APB write
    input  wire logic [7:0]      paddr,    // APB byte address
    input  wire logic [31:0]     pwdata,   // APB write data
    output logic      [31:0]     prdata,   // APB read data
    output logic                 pready,   // APB ready
    output logic                 pslverr,  // APB error
    input  wire logic [IO_W-1:0] in_pins,  // Input terminals
    output logic      [IO_W-1:0] out_pins  // Output terminals
);

    localparam logic [4:0] EDGE_LIM = 5'(N_EDGE);
    localparam logic [PROG_AW-1:0] PC_LAST = PROG_AW'(PROG_DEPTH - 1);

    // ************************************************************
    // Declarations
    // ************************************************************
    lbce_state_t          state_reg, state_next;
    logic [PROG_AW-1:0]   pc_reg, pc_next;
    logic                 cond_reg, cond_next;   // Current line result
    logic                 prev_reg, prev_next;   // Previous line result
    logic                 gate_reg, gate_next;   // Section gate open
    logic [4:0]           eidx_reg, eidx_next;   // Edge instance count
    logic [BIT_COUNT-1:0] bits_reg, bits_next;
    logic [IO_W-1:0]      out_reg, out_next;
    logic                 ovf_reg, ovf_next;
    logic [15:0]          scnt_reg, scnt_next;
    logic                 start_reg, start_next;
    logic                 run_reg, run_next;
    logic [PROG_AW-1:0]   paddr_reg, paddr_next;
    logic [31:0]          prdata_reg, prdata_next;
    logic                 pready_reg, pready_next;
    logic                 pslverr_reg, pslverr_next;
    logic [INSTR_W-1:0]   mem_rdata;
    lbce_instr_t          ins;
    logic                 hist_rd, hist_we, hist_wd;
    logic                 mem_we, start_wr, ovf_clr;
    logic                 apb_setup, apb_acc, busy, opbit, pulse;
    logic [5:0]           exec_addr;

    // ************************************************************
    // Sub-blocks
    // ************************************************************
    lbce_prog_mem u_prog (
        .pclk  (pclk),
        .ce    (ce),
        .we    (mem_we),
        .waddr (paddr_reg),
        .wdata (pwdata[INSTR_W-1:0]),
        .raddr (pc_reg),
        .rdata (mem_rdata)
    );

    lbce_edge_hist #(.N(N_EDGE)) u_hist (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .idx     (eidx_reg[$clog2(N_EDGE)-1:0]),
        .we      (hist_we),
        .wdata   (hist_wd),
        .rdata   (hist_rd)
    );

    // ************************************************************
    // Scan engine
    // ************************************************************
    // operand in same word
    assign ins       = lbce_instr_t'(mem_rdata);
    assign exec_addr = ins.addr;
    assign opbit     = bits_reg[ins.addr];
    assign busy      = (state_reg != S_IDLE);
    // rising pulse value; falling pulse value
    assign pulse = (ins.opcode == OP_RISE) ? (cond_reg & ~hist_rd)
                                           : (~cond_reg & hist_rd);

    // Next scan state; steps take two cycles (fetch, then execute)
    always_comb begin
        state_next = state_reg;
        pc_next    = pc_reg;
        cond_next  = cond_reg;
        prev_next  = prev_reg;
        gate_next  = gate_reg;
        eidx_next  = eidx_reg;
        bits_next  = bits_reg;
        out_next   = out_reg;
        ovf_next   = ovf_reg;
        scnt_next  = scnt_reg;
        start_next = start_reg;
        hist_we    = 1'b0;
        hist_wd    = cond_reg;
        if (ovf_clr) begin
            ovf_next = 1'b0;
        end
        case (state_reg)
            S_IDLE: begin
                if (run_reg || start_reg) begin
                    start_next = 1'b0;
                    state_next = S_INPUT;
                end
            end
            S_INPUT: begin
                // only input bits load from pins
                bits_next[IN_BASE +: IO_W] = in_pins;
                pc_next    = '0;
                cond_next  = 1'b0;
                prev_next  = 1'b0;
                gate_next  = 1'b1;
                eidx_next  = '0;
                state_next = S_FETCH;
            end
            S_FETCH: begin
                state_next = S_EXEC;
            end
            S_EXEC: begin
                pc_next    = pc_reg + 1'b1;
                state_next = (pc_reg == PC_LAST) ? S_OUTPUT : S_FETCH;
                case (ins.opcode)
                    OP_LINE: begin
                        prev_next = cond_reg;
                        cond_next = opbit;
                    end
                    OP_LINE_NOT: begin
                        prev_next = cond_reg;
                        cond_next = ~opbit;
                    end
                    OP_AND:     cond_next = cond_reg & opbit;
                    OP_AND_NOT: cond_next = cond_reg & ~opbit;
                    OP_OR:      cond_next = cond_reg | opbit;
                    OP_OR_NOT:  cond_next = cond_reg | ~opbit;
                    OP_GATE_BEGIN: begin
                        // Nested gates only narrow the open section
                        gate_next = gate_reg & cond_reg;
                    end
                    OP_GATE_CLEAR: gate_next = 1'b1;
                    // coil ends the line on one bit
                    OP_COIL: begin
                        // closed section clears a sealed coil
                        // sealed bit persists via bit memory
                        bits_next[ins.addr] = gate_reg & cond_reg;
                    end
                    OP_COIL_NOT: begin
                        bits_next[ins.addr] = gate_reg & ~cond_reg;
                    end
                    OP_RISE, OP_FALL: begin
                        if (eidx_reg == EDGE_LIM) begin
                            ovf_next = 1'b1;
                        end else begin
                            eidx_next = eidx_reg + 1'b1;
                            if (gate_reg) begin
                                hist_we = 1'b1;
                                bits_next[ins.addr] = pulse;
                            end
                        end
                    end
                    OP_LATCH: begin
                        if (gate_reg) begin
                            if (cond_reg) begin
                                bits_next[ins.addr] = 1'b0;
                            end else if (prev_reg) begin
                                bits_next[ins.addr] = 1'b1;
                            end
                        end
                    end
                    OP_END: state_next = S_OUTPUT;
                    default: begin
                        // Unknown steps are skipped
                    end
                endcase
            end
            S_OUTPUT: begin
                // only output bits reach the pins
                out_next   = bits_reg[OUT_BASE +: IO_W];
                scnt_next  = scnt_reg + 1'b1;
                state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
        // Software start wins over the clear on scan entry
        if (start_wr) begin
            start_next = 1'b1;
        end
    end

    // Scan registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            pc_reg    <= '0;
            cond_reg  <= 1'b0;
            prev_reg  <= 1'b0;
            gate_reg  <= 1'b1;
            eidx_reg  <= '0;
            bits_reg  <= '0;
            out_reg   <= '0;
            ovf_reg   <= 1'b0;
            scnt_reg  <= '0;
            start_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            cond_reg  <= cond_next;
            prev_reg  <= prev_next;
            gate_reg  <= gate_next;
            eidx_reg  <= eidx_next;
            bits_reg  <= bits_next;
            out_reg   <= out_next;
            ovf_reg   <= ovf_next;
            scnt_reg  <= scnt_next;
            start_reg <= start_next;
        end
    end

    // ************************************************************
    // APB slave, one wait-free access phase
    // ************************************************************
    assign apb_setup = psel & ~penable;
    assign apb_acc   = psel & penable & pready_reg;
    assign mem_we    = apb_acc & pwrite & ~pslverr_reg
                       & (paddr == REG_PDATA);
    assign start_wr  = apb_acc & pwrite & (paddr == REG_CTRL)
                       & pwdata[CTRL_START];
    assign ovf_clr   = apb_acc & pwrite & (paddr == REG_STATUS)
                       & pwdata[STAT_OVF];

    // Decode in setup, answer in the first access cycle
    always_comb begin
        pready_next  = apb_setup;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        run_next     = run_reg;
        paddr_next   = paddr_reg;
        if (apb_setup) begin
            prdata_next  = RST_WORD;
            pslverr_next = 1'b0;
            case (paddr)
                REG_CTRL: prdata_next[CTRL_RUN] = run_reg;
                REG_STATUS: begin
                    prdata_next[STAT_BUSY] = busy;
                    prdata_next[STAT_OVF]  = ovf_reg;
                    prdata_next[STAT_CNT +: 16] = scnt_reg;
                end
                REG_PADDR: prdata_next[PROG_AW-1:0] = paddr_reg;
                // Program is write-only; rewriting mid-scan is refused
                REG_PDATA:   pslverr_next = ~pwrite | busy;
                REG_BITS_LO: prdata_next = bits_reg[31:0];
                REG_BITS_HI: prdata_next = bits_reg[63:32];
                default:     pslverr_next = 1'b1;
            endcase
        end
        if (apb_acc && pwrite && !pslverr_reg) begin
            case (paddr)
                REG_CTRL:  run_next   = pwdata[CTRL_RUN];
                REG_PADDR: paddr_next = pwdata[PROG_AW-1:0];
                REG_PDATA: paddr_next = paddr_reg + 1'b1;
                default: begin
                    // Other writes store nothing here; a status write with bit STAT_OVF set clears the overflow flag in the scan logic
                end
            endcase
        end
    end

    // APB registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= RST_WORD;
            pslverr_reg <= 1'b0;
            run_reg     <= 1'b0;
            paddr_reg   <= '0;
        end else if (ce) begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
            run_reg     <= run_next;
            paddr_reg   <= paddr_next;
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign out_pins = out_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_edge_open(logic [7:0] op);
        ce && state_reg == S_EXEC && ins.opcode == op
        && gate_reg && eidx_reg != EDGE_LIM;
    endsequence

    sequence s_latch(logic g);
        ce && state_reg == S_EXEC && ins.opcode == OP_LATCH
        && gate_reg == g;
    endsequence

    rise_pulse_a: assert property (
        s_edge_open(OP_RISE) ##0 (cond_reg && !hist_rd)
        |=> bits_reg[$past(exec_addr)])
        else $error("rising edge gave no pulse");
    fall_pulse_a: assert property (
        s_edge_open(OP_FALL) ##0 (!cond_reg && hist_rd)
        |=> bits_reg[$past(exec_addr)])
        else $error("falling edge gave no pulse");
    pulse_clear_a: assert property (
        s_edge_open(OP_RISE) ##0 hist_rd
        |=> !bits_reg[$past(exec_addr)])
        else $error("rising pulse not cleared");
    fall_hold_a: assert property (
        s_edge_open(OP_FALL) ##0 !hist_rd
        |=> !bits_reg[$past(exec_addr)])
        else $error("falling pulse operand not held off");
    edge_limit_a: assert property (
        ce && state_reg == S_EXEC && eidx_reg == EDGE_LIM
        && (ins.opcode == OP_RISE || ins.opcode == OP_FALL)
        |=> ovf_reg && eidx_reg == EDGE_LIM)
        else $error("edge instance limit not flagged");
    latch_set_a: assert property (
        s_latch(1'b1) ##0 (prev_reg && !cond_reg)
        |=> bits_reg[$past(exec_addr)])
        else $error("latch did not set");
    latch_reset_a: assert property (
        s_latch(1'b1) ##0 cond_reg
        |=> !bits_reg[$past(exec_addr)])
        else $error("latch reset did not win");
    latch_hold_a: assert property (
        s_latch(1'b0)
        |=> bits_reg[$past(exec_addr)] == $past(opbit))
        else $error("latch changed in closed section");
    coil_gate_a: assert property (
        ce && state_reg == S_EXEC && ins.opcode == OP_COIL && !gate_reg
        |=> !bits_reg[$past(exec_addr)])
        else $error("coil on in closed section");
    work_private_a: assert property (
        ce && state_reg == S_INPUT
        |=> bits_reg[63:OUT_BASE] == $past(bits_reg[63:OUT_BASE])
        ##1 1'b1)
        else $error("work bits touched by input copy");
    scan_flow_a: assert property (
        ce && state_reg == S_EXEC && ins.opcode == OP_GATE_BEGIN
        && !cond_reg |=> !gate_reg)
        else $error("gate stayed open on OFF condition");

endmodule

// >>> design/lbce_pkg.sv
/*
 * Package for the ladder bit-control engine: opcodes, register map,
 * field positions, reset values, scan states and the instruction word.
 * Assumes every design file imports it whole.
 */
package lbce_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int unsigned PROG_DEPTH = 64;   // Program steps
    localparam int unsigned PROG_AW    = 6;    // Program address width
    localparam int unsigned INSTR_W    = 16;   // Instruction word width
    localparam int unsigned BIT_COUNT  = 64;   // Bit data memory size
    localparam int unsigned EDGE_MAX   = 16;   // Edge-pulse instances
    localparam int unsigned IO_W       = 16;   // Input and output pins
    localparam int unsigned IN_BASE    = 0;    // First input bit
    localparam int unsigned OUT_BASE   = 16;   // First output bit

    // ************************************************************
    // Opcodes (function codes)
    // ************************************************************
    localparam logic [7:0] OP_END        = 8'h01;
    localparam logic [7:0] OP_GATE_BEGIN = 8'h02;
    localparam logic [7:0] OP_GATE_CLEAR = 8'h03;
    localparam logic [7:0] OP_RISE       = 8'h0A;  // Decimal 10
    localparam logic [7:0] OP_FALL       = 8'h0B;  // Decimal 11
    localparam logic [7:0] OP_LATCH      = 8'h0C;  // Decimal 12
    localparam logic [7:0] OP_LINE       = 8'h20;
    localparam logic [7:0] OP_LINE_NOT   = 8'h21;
    localparam logic [7:0] OP_AND        = 8'h22;
    localparam logic [7:0] OP_AND_NOT    = 8'h23;
    localparam logic [7:0] OP_OR         = 8'h24;
    localparam logic [7:0] OP_OR_NOT     = 8'h25;
    localparam logic [7:0] OP_COIL       = 8'h26;
    localparam logic [7:0] OP_COIL_NOT   = 8'h27;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_PADDR   = 8'h08;
    localparam logic [7:0] REG_PDATA   = 8'h0C;
    localparam logic [7:0] REG_BITS_LO = 8'h10;
    localparam logic [7:0] REG_BITS_HI = 8'h14;
    localparam int unsigned CTRL_RUN   = 0;
    localparam int unsigned CTRL_START = 1;
    localparam int unsigned STAT_BUSY  = 0;
    localparam int unsigned STAT_OVF   = 1;
    localparam int unsigned STAT_CNT   = 16;   // Scan count LSB
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        S_IDLE, S_INPUT, S_FETCH, S_EXEC, S_OUTPUT
    } lbce_state_t;

    typedef struct packed {
        logic [7:0] opcode;   // Function code
        logic [1:0] rsvd;     // Ignored
        logic [5:0] addr;     // Operand bit address
    } lbce_instr_t;

endpackage

// >>> design/lbce_prog_mem.sv
/*
 * Program memory: one write port, one read port, registered read data.
 * Assumes writer and reader never need the same word in one cycle.
 */
`timescale 1ns/1ns
module lbce_prog_mem
    import lbce_pkg::*;
#(
    parameter int unsigned DEPTH = PROG_DEPTH,
    parameter int unsigned AW    = PROG_AW,
    parameter int unsigned DW    = INSTR_W
) (
    input  wire logic          pclk,   // Clock
    input  wire logic          ce,     // Clock enable
    input  wire logic          we,     // Write strobe
    input  wire logic [AW-1:0] waddr,  // Write address
    input  wire logic [DW-1:0] wdata,  // Write data
    input  wire logic [AW-1:0] raddr,  // Read address
    output logic      [DW-1:0] rdata   // Read data, one cycle late
);

    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_reg;

    // ************************************************************
    // Storage, no reset so it maps onto block RAM
    // ************************************************************
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata_reg <= mem[raddr];
        end
    end

    assign rdata = rdata_reg;

endmodule

// >>> design/lbce_edge_hist.sv
/*
 * Edge history store: one previous-condition bit per edge-pulse
 * instance. Assumes the caller keeps the index below N.
 */
`timescale 1ns/1ns
module lbce_edge_hist
    import lbce_pkg::*;
#(
    parameter int unsigned N = EDGE_MAX
) (
    input  wire logic                 pclk,     // Clock
    input  wire logic                 presetn,  // Async reset, low
    input  wire logic                 ce,       // Clock enable
    input  wire logic [$clog2(N)-1:0] idx,      // Instance number
    input  wire logic                 we,       // Update strobe
    input  wire logic                 wdata,    // New condition
    output logic                      rdata     // Stored condition
);

    logic [N-1:0] hist_reg;
    logic [N-1:0] hist_next;

    // Next history
    always_comb begin
        hist_next = hist_reg;
        if (we) begin
            hist_next[idx] = wdata;
        end
    end

    // History flops, OFF after reset so no pulse is faked at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_reg <= '0;
        end else if (ce) begin
            hist_reg <= hist_next;
        end
    end

    assign rdata = hist_reg[idx];

endmodule

// >>> sim/tb.sv
/* Bench for lbce_top: loads a ladder program over APB, runs scans
 * on corner and random pins, checks bit memory, pins and status.
 * Assumes lbce_pkg opcodes, register map and bit map. */
`timescale 1ns/1ns
module tb
    import lbce_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, pready, pslverr, e, ok, p0 = 0, p1 = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, rs = 32'h48E0;
    logic [15:0] in_pins = '0, out_pins, iv;
    logic [5:0]  wb = '0, m;
    int          errors = 0, n_compared = 0, k, s;
    // Pulse, latch, seal, gated coil, then pin copy of the pulse bit
    // set-reset-latch order, seal reset, work bits and output bit 16
    logic [15:0] prog [22] = '{{OP_LINE, 8'h00}, {OP_RISE, 8'h20},
        {OP_LINE, 8'h01}, {OP_FALL, 8'h21}, {OP_LINE, 8'h02},
        {OP_LINE, 8'h03}, {OP_LATCH, 8'h22}, {OP_LINE, 8'h04},
        {OP_OR, 8'h23}, {OP_AND_NOT, 8'h05}, {OP_COIL, 8'h23},
        {OP_LINE, 8'h06}, {OP_GATE_BEGIN, 8'h00}, {OP_LINE, 8'h07},
        {OP_COIL, 8'h24}, {OP_LINE, 8'h08}, {OP_LINE, 8'h09},
        {OP_LATCH, 8'h25}, {OP_GATE_CLEAR, 8'h00}, {OP_LINE, 8'h20},
        {OP_COIL, 8'h10}, {OP_END, 8'h00}};
    logic [15:0] cor [10] = '{16'h0000, 16'h0015, 16'h0015, 16'h0002,
        16'h0000, 16'h000C, 16'h01C0, 16'h0340, 16'h0100, 16'h0020};

    always #20 pclk = ~pclk;

    lbce_top dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_pins(in_pins), .out_pins(out_pins));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Work bits 37..32 after one scan of the program above
    function automatic logic [5:0] model(input logic [15:0] i);
        logic [5:0] r;
        r = wb;
        r[0] = i[0] & ~p0;
        r[1] = ~i[1] & p1;
        if (i[3]) r[2] = 1'b0;
        else if (i[2]) r[2] = 1'b1;
        r[3] = (i[4] | wb[3]) & ~i[5];
        r[4] = i[6] & i[7];
        // Closed gate leaves the latch alone
        if (i[6] & i[9]) r[5] = 1'b0;
        else if (i[6] & i[8]) r[5] = 1'b1;
        return r;
    endfunction

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        ok = 1'b0;
        for (k = 0; k < 20 && !ok; k++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        if (!ok) begin errors++; results(); end
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Start one scan and poll until the scan count reaches c
    task automatic run_scan(input logic [15:0] c);
        apb(1'b1, REG_CTRL, 32'h2);
        ok = 1'b0;
        for (int w = 0; w < 60 && !ok; w++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            ok = (q[31:16] === c);
        end
        if (!ok) begin errors++; results(); end
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_BITS_LO, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, REG_PADDR, 32'h0);
        foreach (prog[j]) apb(1'b1, REG_PDATA, {16'h0, prog[j]});
        // Unmapped address is refused
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (s = 0; s < 30; s++) begin
            iv = (s < 10) ? cor[s] : rs[15:0];
            rs = lfsr(rs);
            in_pins <= iv;
            m = model(iv);
            p0 = iv[0]; p1 = iv[1]; wb = m;
            run_scan(16'(s + 1));
            apb(1'b0, REG_BITS_LO, 32'h0);
            chk(q, {15'h0, m[0], iv});
            apb(1'b0, REG_BITS_HI, 32'h0);
            chk(q, {26'h0, m});
            chk({16'h0, out_pins}, {31'h0, m[0]});
            $display("scan %0d done", s);
        end
        // Replace the end step by 16 more edge steps: two overflow
        apb(1'b1, REG_PADDR, 32'h15);
        repeat (16) apb(1'b1, REG_PDATA, {16'h0, OP_RISE, 8'h26});
        apb(1'b1, REG_PDATA, {16'h0, OP_END, 8'h00});
        run_scan(16'h1F);
        chk({30'h0, q[1:0]}, 32'h2);
        apb(1'b1, REG_STATUS, 32'h2);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(q, 32'h001F_0000);
        // Program store is write-only and locked while a scan runs
        apb(1'b0, REG_PDATA, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b1, REG_PDATA, {16'h0, OP_END, 8'h00});
        chk({31'h0, e}, 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h1);
        apb(1'b1, REG_CTRL, 32'h0);
        $display("overflow and run mode done");
        results();
    end
endmodule
